// File: watchdog_timeout_reset_pkg.sv
/*
 package for the timeout supervisor: feed keys, counter limits, clock source codes,
 reset values and the feed sequence states.
 assumes nothing of its surroundings.
*/
package watchdog_timeout_reset_pkg;

	// feed keys are arbitrary values picked for this block
	localparam logic [7:0] FEED_KEY_FIRST = 8'hAA;
	localparam logic [7:0] FEED_KEY_SECOND = 8'h55;

	// a reload value of N gives N+1 prescaled ticks, so 8'hFF is the 256 tick floor
	localparam logic [31:0] MIN_RELOAD = 32'h0000_00FF;
	localparam logic [31:0] COUNT_RESET = 32'hFFFF_FFFF;

	localparam logic [1:0] PRESCALE_LAST = 2'h3;
	localparam logic [1:0] PRESCALE_RESET = 2'h0;

	localparam logic [1:0] SRC_RC = 2'h0;
	localparam logic [1:0] SRC_RTC = 2'h1;
	localparam logic [1:0] SRC_PCLK = 2'h2;
	localparam int SRC_COUNT = 3;

	localparam logic [2:0] SYNC_RESET = 3'h0;

	typedef enum logic [0:0] {FEED_IDLE, FEED_HALF} feed_state_type;

endpackage : watchdog_timeout_reset_pkg

// File: source_sync.sv
/*
 two flip-flop synchroniser for the three count clock sources.
 assumes the inputs are free running levels from other clock domains.
*/
module source_sync
	import watchdog_timeout_reset_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic [2:0] i_async,
	output logic [2:0] o_sync
);

	typedef struct packed {
		logic [2:0] stage1;
		logic [2:0] stage2;
	} sync_state_type;

	sync_state_type cur_ff;
	sync_state_type nxt_ff;

	// stage1 feeds stage2 only
	always_comb
	begin
		nxt_ff = cur_ff;
		nxt_ff.stage1 = i_async;
		nxt_ff.stage2 = cur_ff.stage1;
	end

	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			cur_ff <= '{stage1: SYNC_RESET, stage2: SYNC_RESET};
		end
		else
		begin
			cur_ff <= nxt_ff;
		end
	end

	assign o_sync = cur_ff.stage2;

endmodule : source_sync

// File: watchdog_timeout_reset.sv
/*
 timeout supervisor: 32-bit down counter behind a divide-by-4 prescaler, feed sequence
 checker, reset or interrupt response and the supervisor reset flag.
 assumes feed writes, other accesses, enable set and flag clear are one-cycle pulses on
 i_clock; the three count clock sources are slower than i_clock/2 so edges are seen.
*/
module watchdog_timeout_reset
	import watchdog_timeout_reset_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_enable_set,
	input wire logic i_mode_interrupt,
	input wire logic [31:0] i_timeout_value,
	input wire logic [1:0] i_clock_select,
	input wire logic i_internal_rc_oscillator,
	input wire logic i_rtc_oscillator,
	input wire logic i_pclk_oscillator,
	input wire logic i_feed_write,
	input wire logic [7:0] i_feed_data,
	input wire logic i_other_access,
	input wire logic i_flag_clear,
	output logic o_system_reset,
	output logic o_interrupt,
	output logic o_enabled,
	output logic o_timeout_flag,
	output logic [31:0] o_count
);

	typedef struct packed {
		logic enabled;
		logic flag;
		logic [31:0] count;
		logic [1:0] prescale;
		feed_state_type feed_state;
		logic [2:0] src_last;
		logic reset_pulse;
		logic irq_pulse;
	} wd_state_type;

	wd_state_type cur_ff;
	wd_state_type nxt_ff;

	logic [2:0] src_sync;
	logic [2:0] src_edge;
	logic supervisor_count_clock;
	logic tick;
	logic feed_first;
	logic feed_done;
	logic feed_bad;
	logic expire;
	logic fire;
	logic reload;
	logic [31:0] reload_value;

	source_sync u_sync (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_async({i_pclk_oscillator, i_rtc_oscillator, i_internal_rc_oscillator}),
		.o_sync(src_sync)
	);

	// sampling limits the pclk source to below half of i_clock
	assign src_edge = src_sync & ~cur_ff.src_last;
	assign supervisor_count_clock = (i_clock_select == SRC_RTC) ? src_edge[1] :
		(i_clock_select == SRC_PCLK) ? src_edge[2] : src_edge[0];
	assign tick = supervisor_count_clock && (cur_ff.prescale == PRESCALE_LAST);

	assign feed_first = i_feed_write && (cur_ff.feed_state == FEED_IDLE) &&
		(i_feed_data == FEED_KEY_FIRST);
	assign feed_done = i_feed_write && (cur_ff.feed_state == FEED_HALF) &&
		(i_feed_data == FEED_KEY_SECOND);
	assign feed_bad = (i_feed_write && !feed_first && !feed_done) ||
		(i_other_access && (cur_ff.feed_state == FEED_HALF));

	assign expire = cur_ff.enabled && tick && (cur_ff.count == 32'h0000_0000);
	assign fire = cur_ff.enabled && (expire || feed_bad);
	// a firing supervisor wins over a feed completed in the same cycle
	assign reload = !fire && (feed_done || (i_enable_set && !cur_ff.enabled));
	assign reload_value = (i_timeout_value < MIN_RELOAD) ? MIN_RELOAD : i_timeout_value;

	always_comb
	begin
		nxt_ff = cur_ff;
		nxt_ff.src_last = src_sync;
		nxt_ff.reset_pulse = 1'b0;
		nxt_ff.irq_pulse = 1'b0;
		if (supervisor_count_clock)
		begin
			nxt_ff.prescale = cur_ff.prescale + 2'h1;
		end
		if (feed_first)
		begin
			nxt_ff.feed_state = FEED_HALF;
		end
		else if (i_feed_write || i_other_access)
		begin
			nxt_ff.feed_state = FEED_IDLE;
		end
		// clear first so that a reset-mode firing in the same cycle keeps the flag set
		if (i_flag_clear)
		begin
			nxt_ff.flag = 1'b0;
		end
		if (fire)
		begin
			nxt_ff.enabled = 1'b0;
			nxt_ff.feed_state = FEED_IDLE;
			if (i_mode_interrupt)
			begin
				nxt_ff.irq_pulse = 1'b1;
			end
			else
			begin
				nxt_ff.reset_pulse = 1'b1;
				nxt_ff.flag = 1'b1;
			end
		end
		else
		begin
			if (i_enable_set)
			begin
				nxt_ff.enabled = 1'b1;
			end
			if (reload)
			begin
				nxt_ff.count = reload_value;
			end
			else if (cur_ff.enabled && tick)
			begin
				nxt_ff.count = cur_ff.count - 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			cur_ff <= '{enabled: 1'b0, flag: 1'b0, count: COUNT_RESET,
				prescale: PRESCALE_RESET, feed_state: FEED_IDLE,
				src_last: SYNC_RESET, reset_pulse: 1'b0, irq_pulse: 1'b0};
		end
		else
		begin
			cur_ff <= nxt_ff;
		end
	end

	assign o_system_reset = cur_ff.reset_pulse;
	assign o_interrupt = cur_ff.irq_pulse;
	assign o_enabled = cur_ff.enabled;
	assign o_timeout_flag = cur_ff.flag;
	assign o_count = cur_ff.count;

	AST_EXPIRE_RESET: assert property (@(posedge i_clock) disable iff (i_rst)
		(o_enabled && !i_mode_interrupt && tick && (o_count == 32'h0000_0000))
		|=> (o_system_reset && !o_enabled && !o_interrupt))
		else $error("expiry did not raise a system reset");

	AST_NO_SW_CLEAR: assert property (@(posedge i_clock) disable iff (i_rst)
		(o_enabled && !fire) |=> o_enabled)
		else $error("enable dropped without a firing");

	AST_ENABLE_SET: assert property (@(posedge i_clock) disable iff (i_rst)
		(!o_enabled && i_enable_set) |=> (o_enabled && (o_count == $past(reload_value))))
		else $error("enable set did not enable and load");

	AST_BAD_KEY: assert property (@(posedge i_clock) disable iff (i_rst)
		(o_enabled && i_feed_write && (cur_ff.feed_state == FEED_IDLE) &&
		(i_feed_data != FEED_KEY_FIRST))
		|=> ((o_system_reset != o_interrupt) && !o_enabled))
		else $error("wrong first key did not fire");

	AST_BROKEN_FEED: assert property (@(posedge i_clock) disable iff (i_rst)
		(o_enabled && i_feed_write && (i_feed_data == FEED_KEY_FIRST) && !feed_bad && !expire)
		##1 (i_other_access && !i_feed_write) |=> (o_system_reset || o_interrupt))
		else $error("access between keys did not fire");

	AST_INT_MODE: assert property (@(posedge i_clock) disable iff (i_rst)
		(fire && i_mode_interrupt) |=> (o_interrupt && !o_system_reset && !o_enabled))
		else $error("interrupt mode did not raise the interrupt");

	AST_FLAG_SET: assert property (@(posedge i_clock) disable iff (i_rst)
		o_system_reset |-> (o_timeout_flag && $past(o_enabled)))
		else $error("flag not set with supervisor reset");

	AST_FLAG_HOLD: assert property (@(posedge i_clock) disable iff (i_rst)
		(o_timeout_flag && !i_flag_clear) |=> o_timeout_flag)
		else $error("flag lost without a clear");

	AST_COUNT_DEC: assert property (@(posedge i_clock) disable iff (i_rst)
		(o_enabled && tick && !reload && !fire) |=> (o_count == $past(o_count) - 32'h0000_0001))
		else $error("counter did not step on a tick");

	AST_COUNT_HOLD: assert property (@(posedge i_clock) disable iff (i_rst)
		(!tick && !reload) |=> $stable(o_count))
		else $error("counter moved without a tick");

	AST_MIN_PERIOD: assert property (@(posedge i_clock) disable iff (i_rst)
		reload |=> (o_count >= MIN_RELOAD))
		else $error("reload below the 256 tick floor");

	AST_FEED_RELOAD: assert property (@(posedge i_clock) disable iff (i_rst)
		(feed_done && !fire) |=> (o_count == $past(reload_value)))
		else $error("valid feed did not reload");

	AST_SRC_SELECT: assert property (@(posedge i_clock) disable iff (i_rst)
		((i_clock_select == SRC_RTC) && !src_edge[1]) |-> !tick)
		else $error("tick without an edge of the chosen source");

endmodule : watchdog_timeout_reset

// File: watchdog_timeout_reset_tb_top.sv
/*
 self-checking bench for the timeout supervisor: reset values, enable, feed, source select,
 expiry and fault responses.
 assumes the design package is compiled first; sources are slow toggles made here.
*/
`define CHK(g, e) \
	begin checks++; if ((g) !== (e)) \
	begin miscompares++; $display("mismatch at %0t: got %h want %h", $time, g, e); end end
module watchdog_timeout_reset_tb_top
	import watchdog_timeout_reset_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clock = 1'b0;
	logic i_rst = 1'b1;
	logic i_enable_set = 1'b0;
	logic i_mode_interrupt = 1'b0;
	logic [31:0] i_timeout_value = 32'h0;
	logic [1:0] i_clock_select = 2'h0;
	logic i_feed_write = 1'b0;
	logic [7:0] i_feed_data = 8'h00;
	logic i_other_access = 1'b0;
	logic i_flag_clear = 1'b0;
	logic o_system_reset, o_interrupt, o_enabled, o_timeout_flag;
	logic [31:0] o_count;
	logic [31:0] cnt;
	logic [2:0] src_run = 3'h0;
	logic [1:0] div = 2'h0;
	int checks = 0;
	int miscompares = 0;
	int n;
	always #25 i_clock = ~i_clock;
	// stopped sources sit low so no stray edges reach the prescaler
	always @(negedge i_clock) div <= div + 2'h1;
	watchdog_timeout_reset watchdog_timeout_reset_i (
		.i_clock(i_clock), .i_rst(i_rst), .i_enable_set(i_enable_set),
		.i_mode_interrupt(i_mode_interrupt), .i_timeout_value(i_timeout_value),
		.i_clock_select(i_clock_select), .i_internal_rc_oscillator(src_run[0] & div[1]),
		.i_rtc_oscillator(src_run[1] & div[1]), .i_pclk_oscillator(src_run[2] & div[1]),
		.i_feed_write(i_feed_write), .i_feed_data(i_feed_data),
		.i_other_access(i_other_access), .i_flag_clear(i_flag_clear),
		.o_system_reset(o_system_reset), .o_interrupt(o_interrupt), .o_enabled(o_enabled),
		.o_timeout_flag(o_timeout_flag), .o_count(o_count)
	);
	task automatic step(input int k);
		repeat (k) @(negedge i_clock);
	endtask : step
	task automatic do_reset;
		i_rst = 1'b1;
		step(6);
		i_rst = 1'b0;
		step(1);
	endtask : do_reset
	// which: 0 enable set, 1 feed key, 2 other access, 3 flag clear
	task automatic pulse(input int which, input logic [7:0] d);
		case (which)
			0: i_enable_set = 1'b1;
			1:
			begin
				i_feed_write = 1'b1;
				i_feed_data = d;
			end
			2: i_other_access = 1'b1;
			default: i_flag_clear = 1'b1;
		endcase
		step(1);
		// drop only the strobe raised here, so a following pulse may raise another
		case (which)
			0: i_enable_set = 1'b0;
			1: i_feed_write = 1'b0;
			2: i_other_access = 1'b0;
			default: i_flag_clear = 1'b0;
		endcase
	endtask : pulse
	task automatic feed(input logic [7:0] a, input logic [7:0] b);
		i_feed_write = 1'b1;
		i_feed_data = a;
		step(1);
		i_feed_data = b;
		step(1);
		i_feed_write = 1'b0;
		step(1);
	endtask : feed
	// bounded wait; the pulse stands one cycle so it is polled every cycle
	task automatic wait_fire(output int m);
		m = 0;
		while (!(o_system_reset === 1'b1 || o_interrupt === 1'b1) && m < 6000)
		begin
			step(1);
			m++;
		end
	endtask : wait_fire
	task automatic report_and_stop;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop
	initial
	begin
		step(20000);
		miscompares++;
		report_and_stop();
	end
	initial
	begin
		do_reset();
		`CHK(o_enabled, 1'b0)
		`CHK(o_timeout_flag, 1'b0)
		`CHK(o_count, COUNT_RESET)
		for (int s = 0; s < SRC_COUNT; s++)
		begin
			do_reset();
			i_timeout_value = 32'h0001_0000;
			i_clock_select = s[1:0];
			pulse(0, 8'h00);
			`CHK(o_enabled, 1'b1)
			`CHK(o_count, 32'h0001_0000)
			src_run = 3'h1 << s;
			step(200);
			`CHK(o_count < 32'h0001_0000, 1'b1)
			i_clock_select = 2'((s + 1) % 3);
			step(20);
			cnt = o_count;
			step(100);
			`CHK(o_count, cnt)
			pulse(0, 8'h00);
			`CHK(o_count, cnt)
			feed(FEED_KEY_FIRST, FEED_KEY_SECOND);
			`CHK(o_count, 32'h0001_0000)
			`CHK(o_enabled, 1'b1)
			src_run = 3'h0;
		end
		do_reset();
		i_timeout_value = 32'h0;
		i_clock_select = SRC_PCLK;
		pulse(0, 8'h00);
		`CHK(o_count, MIN_RELOAD)
		src_run = 3'h4;
		wait_fire(n);
		`CHK(o_system_reset, 1'b1)
		`CHK(o_interrupt, 1'b0)
		`CHK(n > 4000 && n < 4150, 1'b1)
		`CHK(o_enabled, 1'b0)
		`CHK(o_timeout_flag, 1'b1)
		step(1);
		`CHK(o_system_reset, 1'b0)
		pulse(3, 8'h00);
		`CHK(o_timeout_flag, 1'b0)
		src_run = 3'h0;
		i_mode_interrupt = 1'b1;
		step(1);
		pulse(0, 8'h00);
		pulse(1, FEED_KEY_FIRST);
		pulse(2, 8'h00);
		wait_fire(n);
		`CHK(o_interrupt, 1'b1)
		`CHK(o_enabled, 1'b0)
		`CHK(o_timeout_flag, 1'b0)
		step(1);
		pulse(0, 8'h00);
		step(1);
		pulse(1, 8'h12);
		wait_fire(n);
		`CHK(o_interrupt, 1'b1)
		`CHK(o_system_reset, 1'b0)
		// select code 3 counts from the rc source
		do_reset();
		i_clock_select = 2'h3;
		pulse(0, 8'h00);
		src_run = 3'h1;
		step(200);
		`CHK(o_count < MIN_RELOAD, 1'b1)
		src_run = 3'h2;
		step(20);
		cnt = o_count;
		step(100);
		`CHK(o_count, cnt)
		report_and_stop();
	end
endmodule : watchdog_timeout_reset_tb_top
